// file: verilog/fps_defines.svh
// timing counts, reset values and encodings for the flash programming sequencer
`ifndef FPS_DEFINES_SVH
`define FPS_DEFINES_SVH

// system clock rate in hertz
`define FPS_CLK_HZ 50000000
// slowest and reset-time bit rates of the asynchronous channel, bit/s
`define FPS_BAUD_MIN 4800
`define FPS_BAUD_RESET 9600
// fastest rate step: rate = 4800 << step, step 4 gives 76800 bit/s
`define FPS_BAUD_STEP_MAX 3'h4
`define FPS_BAUD_STEP_RESET 3'h1
// bit periods of the slowest rate, in system cycles
`define FPS_DIV_MIN_RATE (`FPS_CLK_HZ / `FPS_BAUD_MIN)
// quiet time on the pulse pin that closes channel selection, in microseconds
`define FPS_SEL_QUIET_US 200
`define FPS_SEL_QUIET_CYC ((`FPS_SEL_QUIET_US * (`FPS_CLK_HZ / 1000000)))
// pulse counts that select a channel, and the highest legal count
`define FPS_PULSES_CLOCKED 5'h00
`define FPS_PULSES_ASYNC 5'h08
`define FPS_PULSES_MAX 5'h10
// signature word values: killed and erased
`define FPS_SIG_KILLED 32'h00000000
`define FPS_SIG_ERASED 32'hFFFFFFFF
// word offsets of the two signatures
`define FPS_SIG_OFFS_LOWER 20'h00008
`define FPS_SIG_OFFS_UPPER 20'h20008
// area select bit of a flash byte address (two 128 KB areas)
`define FPS_AREA_BIT 17
// idle level of the serial lines
`define FPS_LINE_IDLE 1'h1

`endif

// file: verilog/fps_pkg.sv
// types shared by the flash programming sequencer files
package fps_pkg;

  // top-level sequencer states
  typedef enum logic [2:0] {
    FPS_BOOT_CHECK,
    FPS_NORMAL,
    FPS_PROG_SELECT,
    FPS_PROG_CLOCKED,
    FPS_PROG_ASYNC,
    FPS_PROG_INVALID,
    FPS_SELF_PROG
  } fps_state_t;

  // one byte with its valid mark, used on both stream directions
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fps_byte_t;

  // signature location as read from the flash array
  typedef struct packed {
    logic marker;
    logic [31:0] word;
  } fps_sig_t;

endpackage

// file: verilog/fps_csi_slave.sv
// clocked serial slave on the writer's shift clock, msb first
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"

module fps_csi_slave (
  input wire logic clocked_serial_clock,
  input wire logic link_enable,
  input wire logic clocked_serial_in,
  output logic clocked_serial_out,
  input wire logic [7:0] tx_byte,
  input wire logic tx_toggle,
  output logic [7:0] rx_byte,
  output logic rx_toggle
);

  // enable and transmit toggle arrive from the system domain
  logic en_meta_reg;
  logic en_reg;
  logic tgl_meta_reg;
  logic tgl_reg;
  logic tgl_seen_reg; // last toggle value already loaded
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] tx_shift_reg;

  // two-flop crossing of the control levels; the clock only runs in frames
  always_ff @(posedge clocked_serial_clock) begin
    en_meta_reg <= link_enable;
    en_reg <= en_meta_reg;
    tgl_meta_reg <= tx_toggle;
    tgl_reg <= tgl_meta_reg;
  end

  always_ff @(posedge clocked_serial_clock) begin
    if (!en_reg) begin
      bit_cnt_reg <= 3'h0;
      shift_in_reg <= 8'h00;
      rx_byte <= 8'h00;
      rx_toggle <= 1'h0;
    end else begin
      shift_in_reg <= {shift_in_reg[6:0], clocked_serial_in};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      // eighth bit closes the byte and flags it across
      if (bit_cnt_reg == 3'h7) begin
        rx_byte <= {shift_in_reg[6:0], clocked_serial_in};
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // transmit word taken at byte borders; tx_byte held while toggled
  always_ff @(posedge clocked_serial_clock) begin
    if (!en_reg) begin
      tx_shift_reg <= 8'hFF;
      tgl_seen_reg <= 1'h0;
    end else if (bit_cnt_reg == 3'h7) begin
      // nothing new queued: send all ones
      tx_shift_reg <= (tgl_reg != tgl_seen_reg) ? tx_byte : 8'hFF;
      tgl_seen_reg <= tgl_reg;
    end
  end

  // out changes on falling edge; writer samples on rising
  always_ff @(negedge clocked_serial_clock) begin
    if (!en_reg) begin
      clocked_serial_out <= `FPS_LINE_IDLE;
    end else begin
      clocked_serial_out <= tx_shift_reg[3'h7 - bit_cnt_reg];
    end
  end

endmodule
`default_nettype wire

// file: verilog/fps_sequencer.sv
// flash programming mode entry, channel selection, pin control and boot area swap
// Operation
// - write-level vpp at reset release, or software, enters
// - count vpp pulses, at most sixteen
// - zero pulses: clocked slave channel, msb first
// - eight pulses: async channel at 9600, lsb first
// - async rates 4800 to 76800, lsb first
// - runs on own crystal, writer clock optional
// - non-writer port pins high impedance in mode
// - unused pins keep their after-reset state
// - each area erased only as a whole
// - signature at 08H or 20008H picks boot area
// - after each reset map signed area to zero
// - signature needs internal marker, not user data
// - all-zero word kills a signature
// - swap request exchanges the two areas
// - any boot size up to one area
// - two equal separately erasable areas
// - erased word reads as all ones
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"

module fps_sequencer #(
  parameter int PORT_W = 16, // general port pins that the mode floats
  parameter int QUIET_CYC = `FPS_SEL_QUIET_CYC, // selection close time
  parameter int DIV_MIN_RATE = `FPS_DIV_MIN_RATE // bit period at 4800 bit/s
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic vpp_write_level, // vpp comparator: write voltage present
  input wire logic vpp_pulse_in, // vpp pulse detector output
  input wire logic self_prog_request, // software enters self-programming
  input wire logic writer_clock_output, // writer clock present, optional
  output logic clock_from_writer, // clock mux select
  input wire logic [PORT_W-1:0] app_port_oe, // application port enables
  output logic [PORT_W-1:0] port_oe,
  input wire fps_pkg::fps_sig_t sig_lower, // signature location, lower area
  input wire fps_pkg::fps_sig_t sig_upper, // signature location, upper area
  input wire logic swap_request,
  input wire logic [1:0] erase_request, // bit n: erase logical area n
  output logic [1:0] erase_strobe, // bit n: erase physical area n
  input wire logic [19:0] cpu_addr,
  output logic [19:0] flash_addr,
  output logic upper_at_zero,
  output logic prog_mode,
  output logic [4:0] pulse_count,
  input wire logic [2:0] baud_step, // rate = 4800 << step
  input wire logic baud_load,
  input wire logic clocked_serial_clock,
  input wire logic clocked_serial_in,
  output logic clocked_serial_out,
  output logic clocked_serial_out_oe,
  input wire logic async_receive_pin,
  output logic async_transmit_pin,
  output logic async_transmit_oe,
  input wire fps_pkg::fps_byte_t host_tx, // byte to send to the writer
  output logic host_tx_ready,
  output fps_pkg::fps_byte_t host_rx // byte from the writer, one-cycle valid
);

  fps_pkg::fps_state_t state_reg;
  // pin synchronisers, first stage read only by the second
  logic vpp_lvl_meta_reg;
  logic vpp_lvl_reg;
  logic vpp_pls_meta_reg;
  logic vpp_pls_reg;
  logic vpp_pls_last_reg; // for rising edge of the pulse input
  logic wclk_meta_reg;
  logic wclk_reg;
  logic rxd_meta_reg;
  logic rxd_reg;
  // crossing of the clocked-channel receive toggle
  logic csi_rx_tgl_link;
  logic csi_rx_meta_reg;
  logic csi_rx_sync_reg;
  logic csi_rx_last_reg;
  logic [7:0] csi_rx_byte_link;
  logic [7:0] csi_tx_byte_reg; // held stable while the link loads it
  logic csi_tx_tgl_reg;
  logic csi_enable_reg;
  logic [$clog2(QUIET_CYC+1)-1:0] quiet_cnt_reg;
  logic [2:0] step_reg; // current async rate step
  logic [$clog2(DIV_MIN_RATE+1)-1:0] div_reg; // active bit period
  // async transmitter
  logic [9:0] utx_shift_reg;
  logic [3:0] utx_bits_reg;
  logic [$clog2(DIV_MIN_RATE+1)-1:0] utx_cnt_reg;
  // async receiver
  logic [7:0] urx_shift_reg;
  logic [3:0] urx_bits_reg;
  logic [$clog2(DIV_MIN_RATE+1)-1:0] urx_cnt_reg;
  logic urx_busy_reg;
  logic lower_ok;
  logic upper_ok;
  logic csi_rx_event;
  logic async_on;

  // two-flop capture of the vpp, writer clock and async receive pins, and of the link receive toggle
  always_ff @(posedge clk) begin
    vpp_lvl_meta_reg <= vpp_write_level;
    vpp_lvl_reg <= vpp_lvl_meta_reg;
    vpp_pls_meta_reg <= vpp_pulse_in;
    vpp_pls_reg <= vpp_pls_meta_reg;
    wclk_meta_reg <= writer_clock_output;
    wclk_reg <= wclk_meta_reg;
    rxd_meta_reg <= async_receive_pin;
    rxd_reg <= rxd_meta_reg;
    csi_rx_meta_reg <= csi_rx_tgl_link;
    csi_rx_sync_reg <= csi_rx_meta_reg;
  end
  // marker and live word both needed; zero kills
  assign lower_ok = sig_lower.marker && (sig_lower.word != `FPS_SIG_KILLED) &&
                    (sig_lower.word != `FPS_SIG_ERASED);
  assign upper_ok = sig_upper.marker && (sig_upper.word != `FPS_SIG_KILLED) &&
                    (sig_upper.word != `FPS_SIG_ERASED);
  assign csi_rx_event = csi_rx_sync_reg ^ csi_rx_last_reg;
  assign async_on = (state_reg == fps_pkg::FPS_PROG_ASYNC);
  // main sequence: boot check, mode entry, channel selection
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= fps_pkg::FPS_BOOT_CHECK;
    end else begin
      case (state_reg)
        // vpp level is read in the first cycle after the reset release
        fps_pkg::FPS_BOOT_CHECK: begin
          state_reg <= vpp_lvl_reg ? fps_pkg::FPS_PROG_SELECT : fps_pkg::FPS_NORMAL;
        end
        // software may enter self-programming from normal running
        fps_pkg::FPS_NORMAL: begin
          if (self_prog_request) begin
            state_reg <= fps_pkg::FPS_SELF_PROG;
          end
        end
        // selection closes after a quiet time with no pulse
        fps_pkg::FPS_PROG_SELECT: begin
          if (quiet_cnt_reg == QUIET_CYC[$bits(quiet_cnt_reg)-1:0]) begin
            if (pulse_count == `FPS_PULSES_CLOCKED) begin
              state_reg <= fps_pkg::FPS_PROG_CLOCKED;
            end else if (pulse_count == `FPS_PULSES_ASYNC) begin
              state_reg <= fps_pkg::FPS_PROG_ASYNC;
            end else begin
              // reserved or oversized counts open no channel
              state_reg <= fps_pkg::FPS_PROG_INVALID;
            end
          end
        end
        // only a new reset leaves the programming states
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end
  // pulse counter with quiet timer; saturates one above sixteen
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pulse_count <= 5'h00;
      quiet_cnt_reg <= '0;
      vpp_pls_last_reg <= 1'h0;
    end else begin
      vpp_pls_last_reg <= vpp_pls_reg;
      if (state_reg == fps_pkg::FPS_PROG_SELECT) begin
        if (vpp_pls_reg && !vpp_pls_last_reg) begin
          quiet_cnt_reg <= '0;
          if (pulse_count <= `FPS_PULSES_MAX) begin
            pulse_count <= pulse_count + 5'h01;
          end
        end else if (quiet_cnt_reg != QUIET_CYC[$bits(quiet_cnt_reg)-1:0]) begin
          quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
        end
      end
    end
  end
  // port enables: in the mode they keep the reset state, all floating
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      port_oe <= '0;
      prog_mode <= 1'h0;
      clock_from_writer <= 1'h0;
    end else begin
      prog_mode <= (state_reg != fps_pkg::FPS_NORMAL) && (state_reg != fps_pkg::FPS_BOOT_CHECK);
      // self-programming keeps the application pins alive
      port_oe <= (state_reg == fps_pkg::FPS_NORMAL || state_reg == fps_pkg::FPS_SELF_PROG) ?
                 app_port_oe : '0;
      // own crystal unless the writer actually supplies a clock
      clock_from_writer <= wclk_reg;
    end
  end
  // map at every reset; pick by signature; lower by default
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      upper_at_zero <= 1'h0;
    end else if (state_reg == fps_pkg::FPS_BOOT_CHECK) begin
      upper_at_zero <= upper_ok && !lower_ok;
    end else if (swap_request) begin
      // swap exchanges which physical area sits at zero
      upper_at_zero <= ~upper_at_zero;
    end
  end
  // the area bit alone is flipped, so any boot size up to an area works
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_addr <= 20'h00000;
    end else begin
      flash_addr <= cpu_addr ^ {2'h0, upper_at_zero, 17'h00000};
    end
  end
  // erase strobes cover one whole physical area, never part of one
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      erase_strobe <= 2'h0;
    end else begin
      erase_strobe <= upper_at_zero ? {erase_request[0], erase_request[1]} : erase_request;
    end
  end
  // rate starts at 9600 after reset; steps span 4800 to 76800
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      step_reg <= `FPS_BAUD_STEP_RESET;
    end else if (baud_load && baud_step <= `FPS_BAUD_STEP_MAX) begin
      // out-of-range steps are ignored and the old rate stays
      step_reg <= baud_step;
    end
  end
  // bit period follows the rate step one cycle later
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_reg <= '0;
    end else begin
      div_reg <= DIV_MIN_RATE[$bits(div_reg)-1:0] >> step_reg;
    end
  end
  // async transmitter: start bit, eight data bits lsb first, stop bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      utx_shift_reg <= 10'h3FF;
      utx_bits_reg <= 4'h0;
      utx_cnt_reg <= '0;
      async_transmit_pin <= `FPS_LINE_IDLE;
    end else if (utx_bits_reg == 4'h0) begin
      async_transmit_pin <= `FPS_LINE_IDLE;
      if (async_on && host_tx.valid && host_tx_ready) begin
        utx_shift_reg <= {1'b1, host_tx.data, 1'b0};
        utx_bits_reg <= 4'hA;
        utx_cnt_reg <= '0;
      end
    end else begin
      async_transmit_pin <= utx_shift_reg[0];
      if (utx_cnt_reg == div_reg - 1'b1) begin
        utx_cnt_reg <= '0;
        utx_shift_reg <= {1'b1, utx_shift_reg[9:1]};
        utx_bits_reg <= utx_bits_reg - 4'h1;
      end else begin
        utx_cnt_reg <= utx_cnt_reg + 1'b1;
      end
    end
  end
  // async receiver samples mid-bit, lsb first; a bad stop bit drops the byte
  always_ff @(posedge clk) begin
    if (!rst_b || !async_on) begin
      urx_busy_reg <= 1'h0;
      urx_bits_reg <= 4'h0;
      urx_cnt_reg <= '0;
      urx_shift_reg <= 8'h00;
    end else if (!urx_busy_reg) begin
      // start edge: wait half a bit to land mid-bit
      if (!rxd_reg) begin
        urx_busy_reg <= 1'h1;
        urx_bits_reg <= 4'h0;
        urx_cnt_reg <= div_reg >> 1;
      end
    end else if (urx_cnt_reg == div_reg - 1'b1) begin
      urx_cnt_reg <= '0;
      urx_bits_reg <= urx_bits_reg + 4'h1;
      if (urx_bits_reg == 4'h0 && rxd_reg) begin
        // glitch, not a start bit
        urx_busy_reg <= 1'h0;
      end else if (urx_bits_reg == 4'h9) begin
        urx_busy_reg <= 1'h0;
      end else if (urx_bits_reg != 4'h0) begin
        urx_shift_reg <= {rxd_reg, urx_shift_reg[7:1]};
      end
    end else begin
      urx_cnt_reg <= urx_cnt_reg + 1'b1;
    end
  end
  // received bytes from either channel reach the user side as one-cycle pulses
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_rx <= '0;
      csi_rx_last_reg <= 1'h0;
    end else begin
      csi_rx_last_reg <= csi_rx_sync_reg;
      host_rx.valid <= 1'h0;
      if (state_reg == fps_pkg::FPS_PROG_CLOCKED && csi_rx_event) begin
        // link byte is stable for the whole next byte time
        host_rx.valid <= 1'h1;
        host_rx.data <= csi_rx_byte_link;
      end else if (async_on && urx_busy_reg && urx_bits_reg == 4'h9 &&
                   urx_cnt_reg == div_reg - 1'b1 && rxd_reg) begin
        host_rx.valid <= 1'h1;
        host_rx.data <= urx_shift_reg;
      end
    end
  end
  // clocked channel transmit word handed across by toggle; one per exchange
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      csi_tx_byte_reg <= 8'hFF;
      csi_tx_tgl_reg <= 1'h0;
      csi_enable_reg <= 1'h0;
      clocked_serial_out_oe <= 1'h0;
      async_transmit_oe <= 1'h0;
    end else begin
      csi_enable_reg <= (state_reg == fps_pkg::FPS_PROG_CLOCKED);
      clocked_serial_out_oe <= (state_reg == fps_pkg::FPS_PROG_CLOCKED);
      async_transmit_oe <= async_on;
      if (state_reg == fps_pkg::FPS_PROG_CLOCKED && host_tx.valid && host_tx_ready) begin
        csi_tx_byte_reg <= host_tx.data;
        csi_tx_tgl_reg <= ~csi_tx_tgl_reg;
      end
    end
  end
  // ready: async idle, or clocked channel with no byte waiting for an exchange
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      host_tx_ready <= 1'h0;
    end else if (async_on) begin
      host_tx_ready <= (utx_bits_reg == 4'h0) && !(host_tx.valid && host_tx_ready);
    end else if (state_reg == fps_pkg::FPS_PROG_CLOCKED) begin
      if (host_tx.valid && host_tx_ready) begin
        host_tx_ready <= 1'h0;
      end else if (csi_rx_event) begin
        // a finished byte means the queued word was taken into the link shifter at that border; it shifts out in the next byte
        host_tx_ready <= 1'h1;
      end else if (!csi_enable_reg) begin
        host_tx_ready <= 1'h1;
      end
    end else begin
      host_tx_ready <= 1'h0;
    end
  end
  // link-side shifter runs on the writer's shift clock
  fps_csi_slave u_csi (
    .clocked_serial_clock,
    .link_enable(csi_enable_reg),
    .clocked_serial_in,
    .clocked_serial_out,
    .tx_byte(csi_tx_byte_reg),
    .tx_toggle(csi_tx_tgl_reg),
    .rx_byte(csi_rx_byte_link),
    .rx_toggle(csi_rx_tgl_link)
  );

endmodule
`default_nettype wire

// file: verification/fps_sequencer_checker.sv
// port assertions for the flash programming sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
module fps_sequencer_checker #(
  parameter int PORT_W = 16 // floated port width
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic vpp_write_level,
  input wire fps_pkg::fps_sig_t sig_lower,
  input wire fps_pkg::fps_sig_t sig_upper,
  input wire logic swap_request,
  input wire logic [1:0] erase_request,
  input wire logic [1:0] erase_strobe,
  input wire logic [19:0] cpu_addr,
  input wire logic [19:0] flash_addr,
  input wire logic upper_at_zero,
  input wire logic prog_mode,
  input wire logic [4:0] pulse_count,
  input wire logic [PORT_W-1:0] port_oe,
  input wire logic clocked_serial_out_oe,
  input wire logic async_transmit_pin,
  input wire logic async_transmit_oe,
  input wire fps_pkg::fps_byte_t host_tx,
  input wire logic host_tx_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // signature: marker set, neither killed nor erased
  logic lo_ok, up_ok;
  assign lo_ok = sig_lower.marker && sig_lower.word != `FPS_SIG_KILLED && sig_lower.word != `FPS_SIG_ERASED;
  assign up_ok = sig_upper.marker && sig_upper.word != `FPS_SIG_KILLED && sig_upper.word != `FPS_SIG_ERASED;
  a_boot_map: assert property ($rose(rst_b) |-> ##2 upper_at_zero == (up_ok && !lo_ok))
    else $error("boot mapping wrong");
  a_mode_entry: assert property ($rose(rst_b) |-> ##3 prog_mode == vpp_write_level)
    else $error("mode entry wrong");
  a_reset_float: assert property (!$past(rst_b) |-> port_oe == '0 && !prog_mode && async_transmit_pin)
    else $error("reset pin state wrong");
  a_prog_float: assert property (prog_mode && $past(prog_mode) |-> port_oe == '0)
    else $error("port driven in mode");
  a_swap_toggle: assert property (swap_request |=> upper_at_zero != $past(upper_at_zero))
    else $error("swap ignored");
  a_addr_map: assert property ($past(rst_b) |-> flash_addr ==
    ($past(cpu_addr) ^ ({19'h0, $past(upper_at_zero)} << `FPS_AREA_BIT)))
    else $error("flash address wrong");
  a_erase_map: assert property (|erase_request |=> erase_strobe == ($past(upper_at_zero) ?
    {$past(erase_request[0]), $past(erase_request[1])} : $past(erase_request)))
    else $error("erase strobe wrong");
  a_count_sat: assert property (pulse_count <= 5'h11)
    else $error("pulse count past limit");
  a_async_sel: assert property (async_transmit_oe |-> prog_mode && pulse_count == `FPS_PULSES_ASYNC)
    else $error("async channel enabled wrongly");
  a_clocked_sel: assert property (clocked_serial_out_oe |-> prog_mode && pulse_count == `FPS_PULSES_CLOCKED)
    else $error("clocked channel enabled wrongly");
  a_tx_start: assert property (host_tx.valid && host_tx_ready && async_transmit_oe |->
    ##[1:3] !async_transmit_pin)
    else $error("no start bit");
endmodule
bind fps_sequencer fps_sequencer_checker #(.PORT_W(PORT_W)) u_chk (.clk, .rst_b, .vpp_write_level,
  .sig_lower, .sig_upper, .swap_request, .erase_request, .erase_strobe, .cpu_addr, .flash_addr,
  .upper_at_zero, .prog_mode, .pulse_count, .port_oe, .clocked_serial_out_oe, .async_transmit_pin,
  .async_transmit_oe, .host_tx, .host_tx_ready);
`default_nettype wire

// file: verification/fps_writer_model.sv
// flash writer model: vpp control and both serial links
`timescale 1ns/1ps
`default_nettype none
module fps_writer_model (
  output logic vpp_write_level,
  output logic vpp_pulse_in,
  output logic async_receive_pin,
  input wire logic async_transmit_pin,
  output logic clocked_serial_clock,
  output logic clocked_serial_in,
  input wire logic clocked_serial_out
);
  int bit_ns = 640; // async bit time, set by the bench
  // vpp grounded, lines parked
  initial begin
    vpp_write_level = 1'b0;
    vpp_pulse_in = 1'b0;
    async_receive_pin = 1'b1;
    clocked_serial_clock = 1'b1;
    clocked_serial_in = 1'b0;
  end
  task automatic set_vpp(input logic v);
    vpp_write_level = v;
  endtask
  // pulses wide enough for the synchroniser
  task automatic pulse(input int n);
    repeat (n) begin
      #100 vpp_pulse_in = 1'b1;
      #100 vpp_pulse_in = 1'b0;
    end
  endtask
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      async_receive_pin = f[i];
      #(bit_ns);
    end
  endtask
  task automatic uart_recv(output logic [7:0] b);
    wait (async_transmit_pin === 1'b0);
    #(bit_ns * 3 / 2);
    for (int i = 0; i < 8; i++) begin
      b[i] = async_transmit_pin;
      #(bit_ns);
    end
  endtask
  // msb first; the shift clock runs only inside a frame
  task automatic csi_xfer(input logic [7:0] t, output logic [7:0] r, input int n);
    r = 8'h00;
    for (int i = 7; i >= 8 - n; i--) begin
      clocked_serial_clock = 1'b0;
      clocked_serial_in = t[i];
      #24 clocked_serial_clock = 1'b1;
      r[i] = clocked_serial_out;
      #24;
    end
    // released data line shows no stale bit
    clocked_serial_in = ~clocked_serial_in;
  endtask
endmodule
`default_nettype wire

// file: verification/flash_program_mode_boot_swap_tb.sv
// self-checking bench for the flash programming sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fps_defines.svh"
`define CHK(a, e) check(32'(a), 32'(e))
module flash_program_mode_boot_swap_tb;
  localparam int DIV = 64; // bit period at the slowest rate
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic vpp_write_level, vpp_pulse_in, self_prog_request, writer_clock_output, clock_from_writer;
  logic [15:0] app_port_oe, port_oe;
  fps_pkg::fps_sig_t sig_lower, sig_upper;
  logic swap_request, upper_at_zero, prog_mode, baud_load;
  logic [1:0] erase_request, erase_strobe;
  logic [19:0] cpu_addr, flash_addr;
  logic [4:0] pulse_count;
  logic [2:0] baud_step;
  logic clocked_serial_clock, clocked_serial_in, clocked_serial_out, clocked_serial_out_oe;
  logic async_receive_pin, async_transmit_pin, async_transmit_oe, host_tx_ready;
  fps_pkg::fps_byte_t host_tx, host_rx;
  logic [31:0] seed = 32'hF203;
  logic rx_seen = 1'b0;
  logic [7:0] rx_data;
  int miscompares = 0;
  int cmp_count = 0;
  fps_sequencer #(.QUIET_CYC(50), .DIV_MIN_RATE(DIV)) dut (.clk, .rst_b, .vpp_write_level, .vpp_pulse_in,
    .self_prog_request, .writer_clock_output, .clock_from_writer, .app_port_oe, .port_oe, .sig_lower,
    .sig_upper, .swap_request, .erase_request, .erase_strobe, .cpu_addr, .flash_addr, .upper_at_zero,
    .prog_mode, .pulse_count, .baud_step, .baud_load, .clocked_serial_clock, .clocked_serial_in,
    .clocked_serial_out, .clocked_serial_out_oe, .async_receive_pin, .async_transmit_pin,
    .async_transmit_oe, .host_tx, .host_tx_ready, .host_rx);
  fps_writer_model w (.vpp_write_level, .vpp_pulse_in, .async_receive_pin, .async_transmit_pin,
    .clocked_serial_clock, .clocked_serial_in, .clocked_serial_out);
  // 50 MHz system clock
  initial begin
    forever #10 clk = ~clk;
  end
  // latch each one-cycle received byte
  always @(posedge clk) begin
    if (host_rx.valid === 1'b1) begin
      rx_seen <= 1'b1;
      rx_data <= host_rx.data;
    end
  end
  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic sig_ok(input fps_pkg::fps_sig_t s);
    return s.marker && s.word != `FPS_SIG_KILLED && s.word != `FPS_SIG_ERASED;
  endfunction
  task automatic check(input logic [31:0] a, input logic [31:0] e);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic do_reset(input logic v);
    w.set_vpp(v);
    rst_b = 1'b0;
    w.csi_xfer(8'h00, rx_data, 4); // link clears while disabled
    app_port_oe = 16'(rnd());
    writer_clock_output = 1'(rnd());
    repeat (5) @(posedge clk);
    #2 rst_b = 1'b1;
    repeat (4) @(posedge clk);
    #2;
  endtask
  // hold valid until ready is seen at an edge
  task automatic host_send(input logic [7:0] b);
    host_tx = {1'b1, b};
    do @(posedge clk); while (host_tx_ready !== 1'b1);
    #2 host_tx.valid = 1'b0;
  endtask
  task automatic wait_rx();
    for (int t = 0; t < 300 && !rx_seen; t++) @(posedge clk);
    #2;
    `CHK(rx_seen, 1'b1);
  endtask
  // hang guard
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
  initial begin
    int cnt[4] = '{8, 0, 3, 17};
    fps_pkg::fps_sig_t lo, up;
    logic ex;
    logic [7:0] a, b, r, r2;
    {self_prog_request, swap_request, erase_request, baud_step, baud_load, cpu_addr, host_tx} = '0;
    {sig_lower, sig_upper} = '0;
    for (int i = 0; i < 6; i++) begin
      lo = {1'b1, rnd()};
      up = {1'b1, rnd()};
      case (i)
        0: lo.word = `FPS_SIG_KILLED;
        1: lo.word = `FPS_SIG_ERASED;
        2: lo.marker = 1'b0;
        4: {lo.marker, up.marker} = 2'b00;
        default: ;
      endcase
      {sig_lower, sig_upper} = {lo, up};
      ex = sig_ok(up) && !sig_ok(lo);
      do_reset(1'b0);
      `CHK(upper_at_zero, ex);
      `CHK(port_oe, app_port_oe);
      `CHK(clock_from_writer, writer_clock_output);
      cpu_addr = 20'(rnd());
      swap_request = 1'b1;
      @(posedge clk);
      #2 swap_request = 1'b0;
      @(posedge clk);
      #2;
      `CHK(upper_at_zero, !ex);
      `CHK(flash_addr, cpu_addr ^ (20'(!ex) << `FPS_AREA_BIT));
      erase_request = 2'b01;
      @(posedge clk);
      #2 erase_request = 2'b00;
      `CHK(erase_strobe, ex ? 2'b01 : 2'b10);
    end
    // every pulse count class, with traffic on the two channels
    foreach (cnt[k]) begin
      do_reset(1'b1);
      w.pulse(cnt[k]);
      repeat (60) @(posedge clk);
      #2;
      `CHK(prog_mode, 1'b1);
      `CHK(pulse_count, cnt[k] > 16 ? 17 : cnt[k]);
      `CHK(port_oe, 16'h0000);
      `CHK(async_transmit_oe, cnt[k] == 8);
      `CHK(clocked_serial_out_oe, cnt[k] == 0);
      for (int s = 0; s < 2 && cnt[k] == 8; s++) begin
        if (s == 1) begin
          baud_step = `FPS_BAUD_STEP_MAX;
          baud_load = 1'b1;
          @(posedge clk);
          #2 baud_load = 1'b0;
        end
        w.bit_ns = 20 * (DIV >> (s == 1 ? `FPS_BAUD_STEP_MAX : `FPS_BAUD_STEP_RESET));
        a = 8'(rnd());
        fork
          host_send(a);
          w.uart_recv(r);
        join
        `CHK(r, a);
        b = 8'(rnd());
        rx_seen = 1'b0;
        w.uart_send(b);
        wait_rx();
        `CHK(rx_data, b);
      end
      if (cnt[k] == 0) begin
        w.csi_xfer(8'h00, r, 2);
        a = 8'(rnd());
        b = 8'(rnd());
        rx_seen = 1'b0;
        w.csi_xfer(a, r, 8);
        wait_rx();
        `CHK(rx_data, a);
        `CHK(r, 8'hFF);
        host_send(b);
        w.csi_xfer(a, r, 8);
        w.csi_xfer(a, r2, 8);
        `CHK((r === b) || (r2 === b), 1'b1);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
